/* verilog/card_sense_pkg.sv */
// Purpose: shared constants and types for socket sensing and video bypass
// Assumes: 250 MHz core clock, register port described in the top module
// Notes: timing figures in ns, cycle counts derived from them
package card_sense_pkg;

  localparam int CLK_MHZ = 250;
  // card-detect stable time before interrogation starts
  localparam int DEBOUNCE_NS = 16000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  // settle time for each sense drive phase
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;

  // register spaces and offsets
  localparam logic SPACE_CFG = 1'b0;
  localparam logic SPACE_SOCK = 1'b1;
  localparam logic [7:0] OFF_PRESENT = 8'h08;
  localparam logic [7:0] OFF_FORCE = 8'h0c;
  localparam logic [7:0] OFF_SOCK_CTRL = 8'h10;
  localparam logic [7:0] OFF_SYS_CTRL = 8'h80;
  localparam logic [7:0] OFF_CARD_CTRL = 8'h91;
  localparam logic [7:0] OFF_DIAG = 8'h93;

  // field positions
  localparam int BIT_VIDEO_CAP = 27;
  localparam int BIT_RING_OSC = 27;
  localparam int BIT_LEGACY_BYPASS = 6;
  localparam int BIT_STD_DISABLE = 0;
  localparam int BIT_BYPASS_EN = 9;
  localparam int BIT_STD_PRESENT = 10;
  localparam int BIT_IN_USE = 11;
  localparam int VPP_LSB = 0;
  localparam int VCC_LSB = 4;
  localparam int BIT_PRESENT = 0;
  localparam int BIT_POWERED = 3;
  localparam int BIT_KIND_16 = 4;
  localparam int BIT_KIND_CB = 5;
  localparam int BIT_UNKNOWN = 6;
  localparam int BIT_DONE = 8;
  localparam int VOLTS_LSB = 10;

  // reset values
  localparam logic RST_RING_OSC = 1'b1;
  localparam logic RST_STD_DISABLE = 1'b0;
  localparam logic RST_LEGACY_BYPASS = 1'b0;
  localparam logic RST_BYPASS_EN = 1'b0;
  localparam logic RST_VIDEO_CAP = 1'b0;
  localparam logic [2:0] RST_VCC_REQ = 3'h0;
  localparam logic [1:0] RST_VPP_REQ = 2'h0;

  // power request codes and switch select encodings
  localparam logic [2:0] VCC_REQ_5V = 3'h2;
  localparam logic [2:0] VCC_REQ_3V3 = 3'h3;
  localparam logic [1:0] SUPPLY_OFF = 2'h0;
  localparam logic [1:0] SUPPLY_5V = 2'h1;
  localparam logic [1:0] SUPPLY_3V3 = 2'h2;
  localparam logic [1:0] PROG_OFF = 2'h0;

  // voltage capability bit positions
  localparam int VOLT_5V = 0;
  localparam int VOLT_3V3 = 1;
  localparam int VOLT_X = 2;
  localparam int VOLT_Y = 3;

  // sampled pin positions in the idle level vector
  localparam int PIN_VS_A = 0;
  localparam int PIN_VS_B = 1;
  localparam int PIN_CD_A = 2;
  localparam int PIN_CD_B = 3;

  typedef enum logic [1:0] {KIND_NONE, KIND_16BIT, KIND_CARDBUS, KIND_UNKNOWN} card_kind_t;
  typedef enum logic [1:0] {CLS_GND, CLS_TO_A, CLS_TO_B, CLS_OPEN} pin_class_t;

endpackage

/* verilog/card_sense_if.sv */
// Purpose: carries interrogation samples to the decoder and results back
// Assumes: single clock domain
// Notes: levels are 1 for open (pulled up), 0 for ground
`timescale 1ns/1ps
interface card_sense_if;
  logic sample_pulse;
  logic [3:0] idle_lvl;
  logic [1:0] cd_with_a_low;
  logic [1:0] cd_with_b_low;
  logic lv_key;
  card_sense_pkg::card_kind_t kind;
  logic [3:0] volts;

  modport requester
  (
    output sample_pulse, idle_lvl, cd_with_a_low, cd_with_b_low, lv_key,
    input kind, volts
  );
  modport decoder
  (
    input sample_pulse, idle_lvl, cd_with_a_low, cd_with_b_low, lv_key,
    output kind, volts
  );
endinterface

/* verilog/card_decode.sv */
// Purpose: turns strap samples into card kind and supply capabilities
// Assumes: samples held stable while sample_pulse is high
// Notes: result registered one cycle after sample_pulse
`timescale 1ns/1ps
module card_decode
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  card_sense_if.decoder sense
);

  card_sense_pkg::card_kind_t kind;
  card_sense_pkg::card_kind_t next_kind;
  logic [3:0] volts;
  logic [3:0] next_volts;
  card_sense_pkg::pin_class_t cls_a;
  card_sense_pkg::pin_class_t cls_b;

  function automatic card_sense_pkg::pin_class_t classify
  (
    input logic idle,
    input logic with_a,
    input logic with_b
  );
    if (!idle)
      return card_sense_pkg::CLS_GND;
    else if (!with_a)
      return card_sense_pkg::CLS_TO_A;
    else if (!with_b)
      return card_sense_pkg::CLS_TO_B;
    else
      return card_sense_pkg::CLS_OPEN;
  endfunction

  always_comb
  begin
    cls_a = classify(sense.idle_lvl[card_sense_pkg::PIN_CD_A], sense.cd_with_a_low[0],
      sense.cd_with_b_low[0]);
    cls_b = classify(sense.idle_lvl[card_sense_pkg::PIN_CD_B], sense.cd_with_a_low[1],
      sense.cd_with_b_low[1]);
    next_kind = kind;
    next_volts = volts;
    if (sense.sample_pulse)
    begin
      next_kind = card_sense_pkg::KIND_CARDBUS;
      next_volts = 4'h0;
      if (cls_b == card_sense_pkg::CLS_GND && cls_a == card_sense_pkg::CLS_GND)
      begin
        next_kind = card_sense_pkg::KIND_16BIT;
        unique case ({sense.idle_lvl[card_sense_pkg::PIN_VS_B],
                      sense.idle_lvl[card_sense_pkg::PIN_VS_A]})
          2'b11: next_volts = 4'h1;
          2'b10: next_volts = sense.lv_key ? 4'h2 : 4'h3;
          2'b00: next_volts = sense.lv_key ? 4'h6 : 4'h7;
          2'b01: next_volts = 4'h4;
        endcase
      end
      else if (cls_b == card_sense_pkg::CLS_GND && cls_a == card_sense_pkg::CLS_TO_A)
      begin
        if (sense.idle_lvl[card_sense_pkg::PIN_VS_B])
          next_volts = 4'h2;
        else
          next_kind = card_sense_pkg::KIND_UNKNOWN;
      end
      else if (cls_b == card_sense_pkg::CLS_TO_B && cls_a == card_sense_pkg::CLS_GND)
        next_volts = sense.idle_lvl[card_sense_pkg::PIN_VS_A] ? 4'h4 : 4'h6;
      else if (cls_b == card_sense_pkg::CLS_TO_A && cls_a == card_sense_pkg::CLS_GND)
        next_volts = sense.idle_lvl[card_sense_pkg::PIN_VS_B] ? 4'h8 : 4'he;
      else if (cls_b == card_sense_pkg::CLS_GND && cls_a == card_sense_pkg::CLS_TO_B)
      begin
        if (sense.idle_lvl[card_sense_pkg::PIN_VS_A])
          next_volts = 4'hc;
        else
          next_kind = card_sense_pkg::KIND_UNKNOWN;
      end
      else
        next_kind = card_sense_pkg::KIND_UNKNOWN;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      kind <= card_sense_pkg::KIND_NONE;
      volts <= 4'h0;
    end
    else
    begin
      kind <= next_kind;
      volts <= next_volts;
    end
  end

  assign sense.kind = kind;
  assign sense.volts = volts;

endmodule

/* verilog/card_sense_top.sv */
// Purpose: socket card interrogation, power switch control and video bypass
// Assumes: socket pins pulled up off-chip or in the pad, async to clk_in
// Notes: registers reached through a simple two-space register port
//
// How it works
// - cold socket insertion triggers strap interrogation before any power is applied.
// - both detects grounded, 5 V key: sense pattern gives 5, 3.3, X.X V.
// - both detects grounded, low-voltage key: sense pattern gives 3.3 and X.X V, or 5 V with both senses open.
// - detect strapped to a sense pin marks a CardBus card and its voltages; reserved sense patterns mark the card unknown.
// - supply and programming supply selects drive the external power switch.
// - legacy card-control bit 6 floats card address lines 25 to 4.
// - address lines 3 to 0 keep driving while bypass is active.
// - bypass state output and active-low source select follow bypass mode.
// - present-state bit 27 capability changes only via force-event bit 27 writes.
// - socket control bit 11 reads 1 while bypass is active.
// - socket control bit 10 reports standardized model support.
// - socket control bit 9 is a writable bypass enable.
// - diagnostic bit 0 set disables the standardized model.
// - either legacy or socket-control enable can turn bypass on.
// - system control bit 27 enables the ring oscillator, on after reset.
`timescale 1ns/1ps
module card_sense_top
#(
  parameter int DEBOUNCE_CYCLES = card_sense_pkg::DEBOUNCE_CYC,
  parameter int SETTLE_CYCLES = card_sense_pkg::SETTLE_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic card_detect_a_in,
  input wire logic card_detect_b_in,
  input wire logic voltage_sense_a_in,
  output logic voltage_sense_a_out,
  output logic voltage_sense_a_oe_n_out,
  input wire logic voltage_sense_b_in,
  output logic voltage_sense_b_out,
  output logic voltage_sense_b_oe_n_out,
  input wire logic low_voltage_key_in,
  input wire logic [25:0] card_addr_in,
  output logic [25:0] card_addr_out,
  output logic [25:0] card_addr_oe_n_out,
  output logic [1:0] supply_select_out,
  output logic [1:0] prog_supply_select_out,
  output logic video_bypass_state_out,
  output logic video_source_select_n_out,
  output logic ring_osc_enable_out,
  input wire logic reg_space_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_ack_out
);

  typedef enum logic [2:0] {ST_EMPTY, ST_DEBOUNCE, ST_DRIVE_A, ST_DRIVE_B, ST_DECODE,
    ST_READY} socket_state_t;

  card_sense_if sense ();
  card_decode u_decode
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .sense(sense)
  );

  function automatic logic reg_hit(input logic space, input logic [7:0] addr,
    input logic want_space, input logic [7:0] want_addr);
    return (space == want_space) && (addr == want_addr);
  endfunction
  // pin synchronisers: three stages, change accepted when stages two and three agree
  logic [4:0] pin_s1, pin_s2, pin_s3, pin_filt, next_pin_filt;
  always_comb
  begin
    next_pin_filt = pin_filt;
    for (int i = 0; i < 5; i++)
    begin
      if (pin_s2[i] == pin_s3[i])
        next_pin_filt[i] = pin_s3[i];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_s1 <= 5'h0f;
      pin_s2 <= 5'h0f;
      pin_s3 <= 5'h0f;
      pin_filt <= 5'h0f;
    end
    else
    begin
      pin_s1 <= {low_voltage_key_in, card_detect_b_in, card_detect_a_in,
        voltage_sense_b_in, voltage_sense_a_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_filt <= next_pin_filt;
    end
  end

  logic card_present;
  assign card_present = !pin_filt[card_sense_pkg::PIN_CD_A]
    || !pin_filt[card_sense_pkg::PIN_CD_B];
  // interrogation sequencer
  socket_state_t state, next_state;
  logic [card_sense_pkg::CNT_W-1:0] cnt, next_cnt;
  logic [3:0] idle_lvl, next_idle_lvl;
  logic [1:0] cd_a_low, next_cd_a_low, cd_b_low, next_cd_b_low;
  logic key_lv, next_key_lv;
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_idle_lvl = idle_lvl;
    next_cd_a_low = cd_a_low;
    next_cd_b_low = cd_b_low;
    next_key_lv = key_lv;
    unique case (state)
      ST_EMPTY:
      begin
        next_cnt = '0;
        if (card_present)
          next_state = ST_DEBOUNCE;
      end
      ST_DEBOUNCE:
      begin
        if (cnt == card_sense_pkg::CNT_W'(DEBOUNCE_CYCLES - 1))
        begin
          next_idle_lvl = pin_filt[3:0];
          next_key_lv = !pin_filt[4];
          next_cnt = '0;
          next_state = ST_DRIVE_A;
        end
      end
      ST_DRIVE_A, ST_DRIVE_B:
      begin
        if (cnt == card_sense_pkg::CNT_W'(SETTLE_CYCLES - 1))
        begin
          if (state == ST_DRIVE_A)
            next_cd_a_low = pin_filt[3:2];
          else
            next_cd_b_low = pin_filt[3:2];
          next_cnt = '0;
          next_state = (state == ST_DRIVE_A) ? ST_DRIVE_B : ST_DECODE;
        end
      end
      ST_DECODE:
        next_state = ST_READY;
      ST_READY:
        next_cnt = '0;
    endcase
    // removal drops straight back and kills power with it
    if (state != ST_EMPTY && !card_present)
      next_state = ST_EMPTY;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state <= ST_EMPTY;
      cnt <= '0;
      idle_lvl <= 4'hf;
      cd_a_low <= 2'h3;
      cd_b_low <= 2'h3;
      key_lv <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      idle_lvl <= next_idle_lvl;
      cd_a_low <= next_cd_a_low;
      cd_b_low <= next_cd_b_low;
      key_lv <= next_key_lv;
    end
  end

  assign sense.sample_pulse = (state == ST_DECODE);
  assign sense.idle_lvl = idle_lvl;
  assign sense.cd_with_a_low = cd_a_low;
  assign sense.cd_with_b_low = cd_b_low;
  assign sense.lv_key = key_lv;

  // sense pins only pulled low during their drive phase
  assign voltage_sense_a_out = 1'b0;
  assign voltage_sense_b_out = 1'b0;
  assign voltage_sense_a_oe_n_out = (state != ST_DRIVE_A);
  assign voltage_sense_b_oe_n_out = (state != ST_DRIVE_B);
  // software registers
  logic vid_cap, next_vid_cap, bypass_en, next_bypass_en, legacy_en, next_legacy_en;
  logic std_disable, next_std_disable, ring_osc, next_ring_osc;
  logic [2:0] vcc_req, next_vcc_req;
  logic [1:0] vpp_req, next_vpp_req;
  always_comb
  begin
    next_vid_cap = vid_cap;
    next_bypass_en = bypass_en;
    next_legacy_en = legacy_en;
    next_std_disable = std_disable;
    next_ring_osc = ring_osc;
    next_vcc_req = vcc_req;
    next_vpp_req = vpp_req;
    if (reg_wr_in)
    begin
      if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_SOCK,
        card_sense_pkg::OFF_FORCE))
        next_vid_cap = reg_wdata_in[card_sense_pkg::BIT_VIDEO_CAP];
      if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_SOCK,
        card_sense_pkg::OFF_SOCK_CTRL))
      begin
        next_bypass_en = reg_wdata_in[card_sense_pkg::BIT_BYPASS_EN];
        next_vcc_req = reg_wdata_in[card_sense_pkg::VCC_LSB +: 3];
        next_vpp_req = reg_wdata_in[card_sense_pkg::VPP_LSB +: 2];
      end
      if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_CFG,
        card_sense_pkg::OFF_CARD_CTRL))
        next_legacy_en = reg_wdata_in[card_sense_pkg::BIT_LEGACY_BYPASS];
      if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_CFG,
        card_sense_pkg::OFF_DIAG))
        next_std_disable = reg_wdata_in[card_sense_pkg::BIT_STD_DISABLE];
      if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_CFG,
        card_sense_pkg::OFF_SYS_CTRL))
        next_ring_osc = reg_wdata_in[card_sense_pkg::BIT_RING_OSC];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      vid_cap <= card_sense_pkg::RST_VIDEO_CAP;
      bypass_en <= card_sense_pkg::RST_BYPASS_EN;
      legacy_en <= card_sense_pkg::RST_LEGACY_BYPASS;
      std_disable <= card_sense_pkg::RST_STD_DISABLE;
      ring_osc <= card_sense_pkg::RST_RING_OSC;
      vcc_req <= card_sense_pkg::RST_VCC_REQ;
      vpp_req <= card_sense_pkg::RST_VPP_REQ;
    end
    else
    begin
      vid_cap <= next_vid_cap;
      bypass_en <= next_bypass_en;
      legacy_en <= next_legacy_en;
      std_disable <= next_std_disable;
      ring_osc <= next_ring_osc;
      vcc_req <= next_vcc_req;
      vpp_req <= next_vpp_req;
    end
  end

  // socket-control enable counts only while the standardized model is on
  logic bypass_active;
  assign bypass_active = legacy_en || (bypass_en && !std_disable);
  // power switch and card address outputs
  logic card_ok, powered;
  logic [1:0] next_supply, next_prog;
  logic [25:0] next_addr_oe_n;
  assign card_ok = (state == ST_READY) && (sense.kind == card_sense_pkg::KIND_16BIT
    || sense.kind == card_sense_pkg::KIND_CARDBUS);
  assign powered = (supply_select_out != card_sense_pkg::SUPPLY_OFF);

  always_comb
  begin
    next_supply = card_sense_pkg::SUPPLY_OFF;
    if (card_ok && vcc_req == card_sense_pkg::VCC_REQ_5V
      && sense.volts[card_sense_pkg::VOLT_5V])
      next_supply = card_sense_pkg::SUPPLY_5V;
    else if (card_ok && vcc_req == card_sense_pkg::VCC_REQ_3V3
      && sense.volts[card_sense_pkg::VOLT_3V3])
      next_supply = card_sense_pkg::SUPPLY_3V3;
    // programming supply never comes up without the card supply
    next_prog = (next_supply != card_sense_pkg::SUPPLY_OFF) ? vpp_req
      : card_sense_pkg::PROG_OFF;
    next_addr_oe_n = '1;
    if (powered && sense.kind == card_sense_pkg::KIND_16BIT)
    begin
      next_addr_oe_n[3:0] = 4'h0;
      next_addr_oe_n[25:4] = bypass_active ? 22'h3fffff : 22'h000000;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      supply_select_out <= card_sense_pkg::SUPPLY_OFF;
      prog_supply_select_out <= card_sense_pkg::PROG_OFF;
      card_addr_oe_n_out <= '1;
      card_addr_out <= '0;
      video_bypass_state_out <= 1'b0;
      video_source_select_n_out <= 1'b1;
    end
    else
    begin
      supply_select_out <= next_supply;
      prog_supply_select_out <= next_prog;
      card_addr_oe_n_out <= next_addr_oe_n;
      card_addr_out <= card_addr_in;
      video_bypass_state_out <= bypass_active;
      video_source_select_n_out <= !bypass_active;
    end
  end

  assign ring_osc_enable_out = ring_osc;
  // register reads, answered one cycle after the request
  logic [31:0] next_rdata, present_word, sock_ctrl_word;
  always_comb
  begin
    present_word = '0;
    present_word[card_sense_pkg::BIT_PRESENT] = (state != ST_EMPTY);
    present_word[card_sense_pkg::BIT_POWERED] = powered;
    present_word[card_sense_pkg::BIT_KIND_16] = (sense.kind == card_sense_pkg::KIND_16BIT);
    present_word[card_sense_pkg::BIT_KIND_CB] = (sense.kind == card_sense_pkg::KIND_CARDBUS);
    present_word[card_sense_pkg::BIT_UNKNOWN] = (state == ST_READY)
      && (sense.kind == card_sense_pkg::KIND_UNKNOWN);
    present_word[card_sense_pkg::BIT_DONE] = (state == ST_READY);
    present_word[card_sense_pkg::VOLTS_LSB +: 4] = (state == ST_READY) ? sense.volts : 4'h0;
    present_word[card_sense_pkg::BIT_VIDEO_CAP] = vid_cap;
    sock_ctrl_word = '0;
    sock_ctrl_word[card_sense_pkg::VPP_LSB +: 2] = vpp_req;
    sock_ctrl_word[card_sense_pkg::VCC_LSB +: 3] = vcc_req;
    sock_ctrl_word[card_sense_pkg::BIT_BYPASS_EN] = bypass_en;
    sock_ctrl_word[card_sense_pkg::BIT_STD_PRESENT] = !std_disable;
    sock_ctrl_word[card_sense_pkg::BIT_IN_USE] = bypass_active;
    next_rdata = '0;
    if (reg_rd_in)
    begin
      if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_SOCK,
        card_sense_pkg::OFF_PRESENT))
        next_rdata = present_word;
      else if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_SOCK,
        card_sense_pkg::OFF_SOCK_CTRL))
        next_rdata = sock_ctrl_word;
      else if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_CFG,
        card_sense_pkg::OFF_CARD_CTRL))
        next_rdata[card_sense_pkg::BIT_LEGACY_BYPASS] = legacy_en;
      else if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_CFG,
        card_sense_pkg::OFF_DIAG))
        next_rdata[card_sense_pkg::BIT_STD_DISABLE] = std_disable;
      else if (reg_hit(reg_space_in, reg_addr_in, card_sense_pkg::SPACE_CFG,
        card_sense_pkg::OFF_SYS_CTRL))
        next_rdata[card_sense_pkg::BIT_RING_OSC] = ring_osc;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      reg_rdata_out <= '0;
      reg_ack_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out <= next_rdata;
      reg_ack_out <= reg_rd_in || reg_wr_in;
    end
  end

endmodule

/* verification/card_sense_top_properties.sv */
// Purpose: port checks for card_sense_top
// Assumes: one clock domain
// Notes: attached by the bind at the foot
`timescale 1ns/1ps
module card_sense_top_properties
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [25:0] card_addr_in,
  input wire logic [25:0] card_addr_out,
  input wire logic [25:0] card_addr_oe_n_out,
  input wire logic voltage_sense_a_oe_n_out,
  input wire logic voltage_sense_b_oe_n_out,
  input wire logic [1:0] supply_select_out,
  input wire logic [1:0] prog_supply_select_out,
  input wire logic video_bypass_state_out,
  input wire logic video_source_select_n_out,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_ack_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_cold;
    !voltage_sense_a_oe_n_out || !voltage_sense_b_oe_n_out |-> supply_select_out == 2'h0;
  endproperty
  a_cold: assert property (p_cold) else $error("power while probing");
  property p_phase;
    $rose(voltage_sense_a_oe_n_out) |-> $fell(voltage_sense_b_oe_n_out);
  endproperty
  a_phase: assert property (p_phase) else $error("probe phase order");
  property p_prog; supply_select_out == 2'h0 |-> prog_supply_select_out == 2'h0; endproperty
  a_prog: assert property (p_prog) else $error("prog supply without supply");
  property p_float;
    video_bypass_state_out && $past(video_bypass_state_out) |-> &card_addr_oe_n_out[25:4];
  endproperty
  a_float: assert property (p_float) else $error("upper address driven");
  property p_low;
    video_bypass_state_out && $past(rst_b_in) |-> card_addr_out[3:0] == $past(card_addr_in[3:0]);
  endproperty
  a_low: assert property (p_low) else $error("low address lost");
  property p_sel; video_source_select_n_out == !video_bypass_state_out; endproperty
  a_sel: assert property (p_sel) else $error("source select wrong");
  property p_ack; reg_wr_in || reg_rd_in |=> reg_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack_cause; reg_ack_out |-> $past(reg_wr_in) || $past(reg_rd_in); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  c_bypass: cover property ($rose(video_bypass_state_out));
  c_power: cover property ($rose(supply_select_out != 2'h0));
  c_probe: cover property ($fell(voltage_sense_b_oe_n_out));
endmodule
bind card_sense_top card_sense_top_properties chk_u (.*);

/* verification/socket_card_model.sv */
// Purpose: straps of an inserted card seen at the socket pins
// Assumes: pads pull every socket pin up
// Notes: strap {det_b, det_a, sense_b, sense_a}; det 0 gnd, 1 to a, 2 to b, 3 none
`timescale 1ns/1ps
module socket_card_model
(
  input wire logic [5:0] strap_in,
  input wire logic oe_a_n_in,
  input wire logic oe_b_n_in,
  output logic det_a_out,
  output logic det_b_out,
  output logic sense_a_out,
  output logic sense_b_out
);
  wire logic [3:0] lv;
  // a linked sense pin floats high until the socket pulls it low
  assign sense_a_out = strap_in[0] & oe_a_n_in;
  assign sense_b_out = strap_in[1] & oe_b_n_in;
  assign lv = {1'b1, sense_b_out, sense_a_out, 1'b0};
  assign det_a_out = lv[strap_in[3:2]];
  assign det_b_out = lv[strap_in[5:4]];
endmodule

/* verification/card_sense_and_video_bypass_test.sv */
// Purpose: self-checking bench for card sensing and video bypass
// Assumes: debounce and settle shortened to 8 cycles
// Notes: card pins come from socket_card_model
`timescale 1ns/1ps
module card_sense_and_video_bypass_test;
  logic clk_in = 0, rst_b_in = 0, low_voltage_key_in = 1, reg_space_in = 0;
  logic reg_wr_in = 0, reg_rd_in = 0, reg_ack_out, ring_osc_enable_out;
  logic [7:0] reg_addr_in = 8'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rv;
  logic [25:0] card_addr_in = 26'h0, card_addr_out, card_addr_oe_n_out;
  logic card_detect_a_in, card_detect_b_in, voltage_sense_a_in, voltage_sense_b_in;
  logic voltage_sense_a_out, voltage_sense_b_out;
  logic voltage_sense_a_oe_n_out, voltage_sense_b_oe_n_out;
  logic [1:0] supply_select_out, prog_supply_select_out, pr;
  logic video_bypass_state_out, video_source_select_n_out;
  logic [5:0] strap = 6'h3f;
  int n_errors = 0, checks = 0, seed = 66691, k;
  // {key, strap}; key 1 is the 5 V key; reserved pairs last
  logic [6:0] straps [14] = '{7'h43, 7'h42, 7'h40, 7'h02, 7'h07, 7'h00, 7'h22,
    7'h11, 7'h01, 7'h23, 7'h0b, 7'h13, 7'h05, 7'h0a};
  // {volts Y X 3.3 5, cardbus, 16-bit}; zero means unrecognized
  logic [5:0] expv [14] = '{6'h05, 6'h0d, 6'h1d, 6'h09, 6'h0a, 6'h19, 6'h1a,
    6'h3a, 6'h11, 6'h12, 6'h32, 6'h22, 6'h00, 6'h00};
  always #2 clk_in = ~clk_in;
  always @(negedge clk_in) card_addr_in <= $random(seed);
  card_sense_top #(.DEBOUNCE_CYCLES(8), .SETTLE_CYCLES(8)) dut_u (.*);
  socket_card_model card_u (.strap_in(strap), .oe_a_n_in(voltage_sense_a_oe_n_out),
    .oe_b_n_in(voltage_sense_b_oe_n_out), .det_a_out(card_detect_a_in),
    .det_b_out(card_detect_b_in), .sense_a_out(voltage_sense_a_in),
    .sense_b_out(voltage_sense_b_in));

  // power only when recognized and 3.3 V, the requested supply, is accepted
  function automatic logic [31:0] pres(input logic [5:0] e);
    pres = {18'h0, e[5:2], 3'h2, e == 6'h0, e[1:0], (e[1:0] != 2'h0) & e[3], 3'h1};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic s, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_in);
    reg_wr_in = w;
    reg_rd_in = !w;
    reg_space_in = s;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_in);
    rv = reg_rdata_out;
    cmp(reg_ack_out, 1'b1);
    reg_wr_in = 0;
    reg_rd_in = 0;
  endtask
  task automatic rdc(input logic s, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    acc(0, s, a, 32'h0);
    cmp(rv & m, e);
  endtask
  task automatic see(input logic on);
    repeat (2) @(negedge clk_in);
    cmp({video_bypass_state_out, video_source_select_n_out, card_addr_oe_n_out},
      {on, !on, {22{on}}, 4'h0});
    rdc(1, 8'h10, 32'h800, {20'h0, on, 11'h0});
  endtask
  task automatic bypass_flow;
    acc(1, 0, 8'h91, 32'h40);
    see(1);
    acc(1, 0, 8'h91, 32'h0);
    see(0);
    rdc(1, 8'h10, 32'h400, 32'h400);
    acc(1, 1, 8'h0c, 32'h08000000);
    acc(1, 1, 8'h08, 32'h0);
    rdc(1, 8'h08, 32'h08000000, 32'h08000000);
    rdc(1, 8'h10, 32'h800, 32'h0);
    acc(1, 1, 8'h10, {22'h0, 1'b1, 2'h0, 3'h3, 2'h0, pr});
    see(1);
    acc(1, 0, 8'h93, 32'h1);
    see(0);
    rdc(1, 8'h10, 32'h400, 32'h0);
    acc(1, 0, 8'h93, 32'h0);
    acc(1, 1, 8'h10, {25'h0, 3'h3, 2'h0, pr});
    see(0);
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(negedge clk_in);
    rst_b_in = 1;
    cmp({voltage_sense_a_out, voltage_sense_b_out, voltage_sense_a_oe_n_out,
      voltage_sense_b_oe_n_out, supply_select_out, prog_supply_select_out,
      video_bypass_state_out, video_source_select_n_out, ring_osc_enable_out,
      &card_addr_oe_n_out}, 12'h307);
    rdc(0, 8'h91, 32'h40, 32'h0);
    rdc(0, 8'h93, 32'h1, 32'h0);
    rdc(0, 8'h80, 32'h08000000, 32'h08000000);
    acc(1, 0, 8'h80, 32'h0);
    cmp(ring_osc_enable_out, 1'b0);
    rdc(1, 8'h0c, 32'hffffffff, 32'h0);
    rdc(0, 8'h20, 32'hffffffff, 32'h0);
    for (int i = 0; i < 14; i++)
    begin
      pr = $random(seed);
      acc(1, 1, 8'h10, {25'h0, 3'h3, 2'h0, pr});
      low_voltage_key_in = straps[i][6];
      strap = straps[i][5:0];
      rv = 32'h0;
      for (k = 0; k < 40 && !rv[8]; k++)
        acc(0, 1, 8'h08, 32'h0);
      repeat (3) @(negedge clk_in);
      rdc(1, 8'h08, 32'h3d79, pres(expv[i]));
      cmp({prog_supply_select_out, supply_select_out},
        pres(expv[i]) & 32'h8 ? {pr, 2'h2} : 4'h0);
      if (i == 3)
        bypass_flow();
      strap = 6'h3f;
      repeat (8) @(negedge clk_in);
      cmp(supply_select_out, 2'h0);
    end
    give_verdict();
  end
  initial
  begin
    #20000;
    n_errors++;
    give_verdict();
  end
endmodule
